// ==== icw_host_model.sv ====
// Host-side model that reads identify words and writes link enables.
module icw_host_model (
   input  wire logic        core_clk,
   input  wire logic        rd_valid,
   input  wire logic [15:0] rd_data,
   output logic             rd_req,
   output logic [7:0]       rd_idx,
   output logic             feat_en_wr,
   output logic [5:0]       feat_en_val
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      rd_req      = 1'b0;
      rd_idx      = 8'h00;
      feat_en_wr  = 1'b0;
      feat_en_val = 6'h00;
   end

   // The answer stands one cycle only, so it is taken just after the edge
   task automatic read_word(input logic [7:0] idx, output logic vld,
                            output logic [15:0] w);
      @(posedge core_clk);
      rd_req <= 1'b1;
      rd_idx <= idx;
      @(posedge core_clk);
      rd_req <= 1'b0;
      rd_idx <= ~idx;
      #1;
      vld = rd_valid;
      w   = rd_data;
   endtask : read_word

   task automatic write_en(input logic [5:0] v);
      @(posedge core_clk);
      feat_en_wr  <= 1'b1;
      feat_en_val <= v;
      @(posedge core_clk);
      feat_en_wr  <= 1'b0;
      feat_en_val <= ~v;
   endtask : write_en

   // Enable write with the read of the word taken at the very next edge
   task automatic write_then_read(input logic [5:0] v,
                                  input logic [7:0] idx, output logic vld,
                                  output logic [15:0] w);
      @(posedge core_clk);
      feat_en_wr  <= 1'b1;
      feat_en_val <= v;
      @(posedge core_clk);
      feat_en_wr  <= 1'b0;
      feat_en_val <= ~v;
      rd_req      <= 1'b1;
      rd_idx      <= idx;
      @(posedge core_clk);
      rd_req <= 1'b0;
      rd_idx <= ~idx;
      #1;
      vld = rd_valid;
      w   = rd_data;
   endtask : write_then_read

   // Older drives filled command words with all zeros or all ones
   function automatic logic indicated(input logic [15:0] w);
      return (w !== 16'h0000) && (w !== 16'hffff);
   endfunction : indicated
endmodule : icw_host_model

// ==== icw_identify_words.sv ====
// Identify block words 54 to 84: geometry, modes, timing, feature words.
`include "icw_params.svh"

module icw_identify_words (
   input  wire logic            core_clk,
   input  wire logic            reset_n,
   input  wire icw_pkg::icw_cfg_t cfg,
   input  wire logic            rd_req,
   input  wire logic [7:0]      rd_idx,
   input  wire logic            feat_en_wr,
   input  wire logic [5:0]      feat_en_val,
   output logic                 rd_valid,
   output logic [15:0]          rd_data,
   output logic                 modes_valid,
   output logic [5:0]           feat_en
);

   icw_pkg::icw_state_t st_q;
   icw_pkg::icw_state_t st_d;

   logic [47:0] chs_prod;
   logic [31:0] capacity;
   logic [7:0]  mdma_sup_f;
   logic [7:0]  mdma_sel_f;
   logic [15:0] dma_floor;
   logic [15:0] dma_min;
   logic [15:0] dma_rec;
   logic [15:0] pio_fc;
   logic [15:0] pio_nfc;
   logic        dma_fields;
   logic [15:0] word_v;

   // Product is wider than the field; the low words are what is reported
   assign chs_prod = 48'(cfg.cyl) * 48'(cfg.heads) * 48'(cfg.spt);
   assign capacity = chs_prod[31:0];

   always_comb begin
      mdma_sup_f = 8'h00;
      mdma_sel_f = 8'h00;
      dma_floor  = `ICW_MDMA0_NS;
      if (cfg.mdma_sup) begin
         unique case (cfg.mdma_max)
            2'h0: begin
               mdma_sup_f = 8'h01;
               dma_floor  = `ICW_MDMA0_NS;
            end
            2'h1: begin
               mdma_sup_f = 8'h03;
               dma_floor  = `ICW_MDMA1_NS;
            end
            default: begin
               // Mode 3 is not encodable here and is taken as mode 2
               mdma_sup_f = 8'h07;
               dma_floor  = `ICW_MDMA2_NS;
            end
         endcase
         if (cfg.mdma_sel_en && (cfg.mdma_sel <= cfg.mdma_max) &&
             (cfg.mdma_sel != 2'h3)) begin
            mdma_sel_f = 8'h01 << cfg.mdma_sel;
         end
      end
   end

   // Timing fields of an unsupported transfer kind read zero
   always_comb begin
      dma_fields = cfg.mdma_sup && (cfg.mdma_max != 2'h0);
      dma_min    = 16'h0000;
      dma_rec    = 16'h0000;
      if (cfg.mdma_sup) begin
         dma_min = (cfg.dma_min_ns < dma_floor) ? dma_floor
                                                : cfg.dma_min_ns;
         dma_rec = (cfg.dma_rec_ns < dma_min) ? dma_min
                                              : cfg.dma_rec_ns;
      end
      if (cfg.pio4_sup) begin
         pio_fc = `ICW_PIO4_NS;
      end else if (cfg.pio3_sup) begin
         pio_fc = `ICW_PIO3_NS;
      end else begin
         pio_fc = 16'h0000;
      end
      if (cfg.pio3_sup || cfg.pio4_sup) begin
         pio_nfc = (cfg.pio_nfc_ns < pio_fc) ? pio_fc
                                             : cfg.pio_nfc_ns;
      end else begin
         pio_nfc = 16'h0000;
      end
   end

   // Word mux; gaps in 54..84 and anything outside read zero
   always_comb begin
      word_v = 16'h0000;
      unique case (rd_idx)
         `ICW_W_CYL:     word_v = cfg.cyl;
         `ICW_W_HEADS:   word_v = cfg.heads;
         `ICW_W_SPT:     word_v = cfg.spt;
         `ICW_W_CAP_LO:  word_v = capacity[15:0];
         `ICW_W_CAP_HI:  word_v = capacity[31:16];
         `ICW_W_MULT:    word_v = `ICW_MULT_VALID |
                            {15'h0000, cfg.mult_cnt != 8'h00};
         `ICW_W_LBA_LO:  word_v = cfg.lba_total[15:0];
         `ICW_W_LBA_HI:  word_v = cfg.lba_total[31:16];
         `ICW_W_MDMA:    word_v = {mdma_sel_f, mdma_sup_f};
         `ICW_W_PIO:     word_v = {14'h0000, cfg.pio4_sup,
                                   cfg.pio3_sup};
         `ICW_W_DMA_MIN: word_v = dma_min;
         `ICW_W_DMA_REC: word_v = dma_rec;
         `ICW_W_PIO_NFC: word_v = pio_nfc;
         `ICW_W_PIO_FC:  word_v = pio_fc;
         `ICW_W_SCAP:    word_v = {5'h00, cfg.phy_evt, cfg.host_pm,
                                   cfg.ncq, 5'h00, cfg.gen2,
                                   cfg.gen1, 1'b0};
         `ICW_W_SFEAT:   word_v = {9'h000, cfg.sfeat_sup, 1'b0};
         `ICW_W_SEN:     word_v = {9'h000, st_q.feat_en, 1'b0};
         `ICW_W_CMD0: begin
            word_v = `ICW_CMD0_FIXED;
            word_v[`ICW_SEC_BIT] = cfg.security_sup;
            word_v[`ICW_WC_BIT]  = cfg.wcache_sup;
            word_v[`ICW_LA_BIT]  = cfg.lookahead_sup;
         end
         `ICW_W_CMD1: begin
            word_v = `ICW_CMD_VALID;
            word_v[`ICW_APM_BIT] = cfg.apm_sup;
         end
         `ICW_W_CMD2:    word_v = `ICW_CMD_VALID;
         default:        word_v = 16'h0000;
      endcase
   end

   always_comb begin
      st_d          = st_q;
      st_d.rd_valid = rd_req;
      if (rd_req) begin
         st_d.rd_data = word_v;
      end
      // Enables are held only for supported features
      if (feat_en_wr) begin
         st_d.feat_en = feat_en_val & cfg.sfeat_sup;
      end
      st_d.modes_valid = cfg.mdma_sup || cfg.pio3_sup ||
                         cfg.pio4_sup || dma_fields;
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         st_q.feat_en     <= `ICW_FEAT_RST;
         st_q.rd_valid    <= 1'b0;
         st_q.rd_data     <= 16'h0000;
         st_q.modes_valid <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rd_valid    = st_q.rd_valid;
   assign rd_data     = st_q.rd_data;
   assign modes_valid = st_q.modes_valid;
   assign feat_en     = st_q.feat_en;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_read(logic [7:0] idx);
      rd_req && rd_idx == idx;
   endsequence

   property p_mult_rsv;
      s_read(`ICW_W_MULT) |=> rd_valid && rd_data[15:9] == 7'h00;
   endproperty
   a_mult_rsv: assert property (p_mult_rsv)
      else $error("word 59 reserved bits set");

   property p_mult_valid;
      s_read(`ICW_W_MULT) |=> rd_data[8];
   endproperty
   a_mult_valid: assert property (p_mult_valid)
      else $error("word 59 valid bit clear");

   property p_mult_cnt;
      s_read(`ICW_W_MULT) |=>
         rd_data[7:0] == {7'h00, $past(cfg.mult_cnt) != 8'h00};
   endproperty
   a_mult_cnt: assert property (p_mult_cnt)
      else $error("word 59 count not zero or one");

   property p_cap;
      s_read(`ICW_W_CAP_LO) |=> rd_data == $past(capacity[15:0]);
   endproperty
   a_cap: assert property (p_cap)
      else $error("capacity low word wrong");

   property p_mdma_onehot;
      s_read(`ICW_W_MDMA) |=>
         $onehot0(rd_data[15:8]) && rd_data[15:11] == 5'h00;
   endproperty
   a_mdma_onehot: assert property (p_mdma_onehot)
      else $error("mdma selected field not one-hot");

   property p_mdma_cum;
      s_read(`ICW_W_MDMA) |=> rd_data[7:3] == 5'h00 &&
         (!rd_data[2] || rd_data[1]) && (!rd_data[1] || rd_data[0]);
   endproperty
   a_mdma_cum: assert property (p_mdma_cum)
      else $error("mdma supported field not cumulative");

   property p_modes_valid;
      cfg.pio4_sup |=> modes_valid;
   endproperty
   a_modes_valid: assert property (p_modes_valid)
      else $error("word 53 bit 1 missing");

   property p_dma_rec;
      s_read(`ICW_W_DMA_REC) |=> rd_data >= $past(dma_min);
   endproperty
   a_dma_rec: assert property (p_dma_rec)
      else $error("recommended dma cycle below minimum");

   property p_pio_nfc;
      s_read(`ICW_W_PIO_NFC) ##0 cfg.pio4_sup |=> rd_data >= `ICW_PIO4_NS;
   endproperty
   a_pio_nfc: assert property (p_pio_nfc)
      else $error("no-flow pio cycle too short");

   property p_cmd_valid;
      s_read(`ICW_W_CMD2) |=> rd_data == `ICW_CMD_VALID;
   endproperty
   a_cmd_valid: assert property (p_cmd_valid)
      else $error("word 84 not marked valid");

   property p_cmd0;
      s_read(`ICW_W_CMD0) |=> (rd_data & 16'h779d) == `ICW_CMD0_FIXED;
   endproperty
   a_cmd0: assert property (p_cmd0)
      else $error("word 82 fixed bits wrong");

   sequence s_en_write;
      feat_en_wr ##1 (!feat_en_wr ##0 s_read(`ICW_W_SEN));
   endsequence

   property p_en_follow;
      s_en_write |=> rd_data[6:1] ==
         ($past(feat_en_val, 2) & $past(cfg.sfeat_sup, 2));
   endproperty
   a_en_follow: assert property (p_en_follow)
      else $error("enabled word does not follow host write");

   property p_lba;
      s_read(`ICW_W_LBA_HI) |=> rd_data == $past(cfg.lba_total[31:16]);
   endproperty
   a_lba: assert property (p_lba)
      else $error("lba total high word wrong");

   property p_pio_rsv;
      s_read(`ICW_W_PIO) |=> rd_data[15:2] == 14'h0000;
   endproperty
   a_pio_rsv: assert property (p_pio_rsv)
      else $error("pio modes reserved bits set");

   property p_dma_min;
      s_read(`ICW_W_DMA_MIN) ##0 (cfg.mdma_sup && cfg.mdma_max == 2'h1)
         |=> rd_data >= `ICW_MDMA1_NS;
   endproperty
   a_dma_min: assert property (p_dma_min)
      else $error("dma minimum cycle below mode floor");

   property p_unsup_zero;
      s_read(`ICW_W_DMA_MIN) ##0 !cfg.mdma_sup |=> rd_data == 16'h0000;
   endproperty
   a_unsup_zero: assert property (p_unsup_zero)
      else $error("unsupported dma cycle field not zero");

   property p_pio_fc;
      s_read(`ICW_W_PIO_FC) ##0 cfg.pio4_sup |=> rd_data == `ICW_PIO4_NS;
   endproperty
   a_pio_fc: assert property (p_pio_fc)
      else $error("flow pio cycle not fastest mode");

   property p_scap;
      s_read(`ICW_W_SCAP) |=> rd_data[15:11] == 5'h00 &&
         rd_data[7:3] == 5'h00 && !rd_data[0];
   endproperty
   a_scap: assert property (p_scap)
      else $error("serial capability reserved bits set");

   property p_sfeat;
      s_read(`ICW_W_SFEAT) |=> rd_data[15:7] == 9'h000 && !rd_data[0];
   endproperty
   a_sfeat: assert property (p_sfeat)
      else $error("serial feature reserved bits set");

   property p_cmd1;
      s_read(`ICW_W_CMD1) |=> rd_data[15:14] == 2'b01 &&
         rd_data[2:0] == 3'h0 && !rd_data[4];
   endproperty
   a_cmd1: assert property (p_cmd1)
      else $error("word 83 fixed bits wrong");

endmodule : icw_identify_words

// ==== icw_params.svh ====
// Identify capability word constants: word indices, bits, fixed values.
`ifndef ICW_PARAMS_SVH
`define ICW_PARAMS_SVH

`define ICW_W_CYL      8'h36
`define ICW_W_HEADS    8'h37
`define ICW_W_SPT      8'h38
`define ICW_W_CAP_LO   8'h39
`define ICW_W_CAP_HI   8'h3a
`define ICW_W_MULT     8'h3b
`define ICW_W_LBA_LO   8'h3c
`define ICW_W_LBA_HI   8'h3d
`define ICW_W_MDMA     8'h3f
`define ICW_W_PIO      8'h40
`define ICW_W_DMA_MIN  8'h41
`define ICW_W_DMA_REC  8'h42
`define ICW_W_PIO_NFC  8'h43
`define ICW_W_PIO_FC   8'h44
`define ICW_W_SCAP     8'h4c
`define ICW_W_SFEAT    8'h4e
`define ICW_W_SEN      8'h4f
`define ICW_W_CMD0     8'h52
`define ICW_W_CMD1     8'h53
`define ICW_W_CMD2     8'h54

`define ICW_MULT_VALID 16'h0100
`define ICW_CMD0_FIXED 16'h7008
`define ICW_CMD_VALID  16'h4000
`define ICW_SEC_BIT    1
`define ICW_WC_BIT     5
`define ICW_LA_BIT     6
`define ICW_APM_BIT    3
`define ICW_SFEAT_LSB  1
`define ICW_FEAT_RST   6'h00

// Least cycle times of the standard transfer modes, ns
`define ICW_MDMA0_NS   16'h01e0
`define ICW_MDMA1_NS   16'h0096
`define ICW_MDMA2_NS   16'h0078
`define ICW_PIO3_NS    16'h00b4
`define ICW_PIO4_NS    16'h0078

`endif

// ==== icw_pkg.sv ====
// Types for the identify capability word block.
package icw_pkg;

   typedef struct packed {
      logic [15:0] cyl;
      logic [15:0] heads;
      logic [15:0] spt;
      logic [31:0] lba_total;
      logic [7:0]  mult_cnt;
      logic        mdma_sup;
      logic [1:0]  mdma_max;
      logic        mdma_sel_en;
      logic [1:0]  mdma_sel;
      logic        pio3_sup;
      logic        pio4_sup;
      logic [15:0] dma_min_ns;
      logic [15:0] dma_rec_ns;
      logic [15:0] pio_nfc_ns;
      logic [15:0] pio_fc_ns;
      logic        phy_evt;
      logic        host_pm;
      logic        ncq;
      logic        gen2;
      logic        gen1;
      logic [5:0]  sfeat_sup;
      logic        security_sup;
      logic        wcache_sup;
      logic        lookahead_sup;
      logic        apm_sup;
   } icw_cfg_t;

   typedef struct packed {
      logic [5:0]  feat_en;
      logic        rd_valid;
      logic [15:0] rd_data;
      logic        modes_valid;
   } icw_state_t;

endpackage : icw_pkg

// ==== testbench.sv ====
// Self-checking bench for the identify capability words.
`include "icw_params.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic              core_clk;
   logic              reset_n;
   icw_pkg::icw_cfg_t cfg;
   icw_pkg::icw_cfg_t cv;
   logic              rd_req;
   logic [7:0]        rd_idx;
   logic              feat_en_wr;
   logic [5:0]        feat_en_val;
   logic              rd_valid;
   logic [15:0]       rd_data;
   logic              modes_valid;
   logic [5:0]        feat_en;
   int                failures;
   int                checks_done;

   icw_identify_words dut (.core_clk(core_clk), .reset_n(reset_n),
      .cfg(cfg), .rd_req(rd_req), .rd_idx(rd_idx),
      .feat_en_wr(feat_en_wr), .feat_en_val(feat_en_val),
      .rd_valid(rd_valid), .rd_data(rd_data),
      .modes_valid(modes_valid), .feat_en(feat_en));
   icw_host_model host (.core_clk(core_clk), .rd_valid(rd_valid),
      .rd_data(rd_data), .rd_req(rd_req), .rd_idx(rd_idx),
      .feat_en_wr(feat_en_wr), .feat_en_val(feat_en_val));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic conclude;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude

   task automatic check(input string nm, input logic [15:0] seen,
                        input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
      logic        v;
      logic [15:0] w;
      host.read_word(idx, v, w);
      check($sformatf("valid %0d", idx), {15'h0, v}, 16'h0001);
      check($sformatf("word %0d", idx), w, exp);
   endtask : rd

   // Config changes land one edge before the next request is raised
   task automatic setc;
      @(posedge core_clk);
      cfg <= cv;
   endtask : setc

   task automatic t_geom;
      cv.mult_cnt = 8'hff;
      cv.cyl = 16'h3fff;
      cv.heads = 16'h0010;
      cv.spt = 16'h003f;
      cv.lba_total = 32'h0123_4567;
      setc();
      rd(`ICW_W_MULT, 16'h0101);
      rd(`ICW_W_CYL, 16'h3fff);
      rd(`ICW_W_HEADS, 16'h0010);
      rd(`ICW_W_SPT, 16'h003f);
      rd(`ICW_W_CAP_LO, 16'hfc10);
      rd(`ICW_W_CAP_HI, 16'h00fb);
      rd(`ICW_W_LBA_LO, 16'h4567);
      rd(`ICW_W_LBA_HI, 16'h0123);
      cv.mult_cnt = 8'h00;
      setc();
      rd(`ICW_W_MULT, 16'h0100);
      cv.mult_cnt = 8'h08;
      setc();
      rd(`ICW_W_MULT, 16'h0101);
   endtask : t_geom

   task automatic t_mdma;
      logic [15:0] fl;
      cv = '0;
      cv.mdma_sup = 1'b1;
      cv.mdma_sel_en = 1'b1;
      for (int m = 0; m < 3; m++) begin
         fl = (m == 0) ? `ICW_MDMA0_NS :
              (m == 1) ? `ICW_MDMA1_NS : `ICW_MDMA2_NS;
         for (int s = 0; s < 3; s++) begin
            cv.mdma_max = m[1:0];
            cv.mdma_sel = s[1:0];
            setc();
            rd(`ICW_W_MDMA, {(s <= m) ? 8'h01 << s : 8'h00,
                             8'hff >> (7 - m)});
         end
         rd(`ICW_W_DMA_MIN, fl);
         rd(`ICW_W_DMA_REC, fl);
         check("modes_valid", {15'h0, modes_valid}, 16'h0001);
      end
      cv.dma_min_ns = 16'h0200;
      cv.mdma_sel_en = 1'b0;
      setc();
      rd(`ICW_W_MDMA, 16'h0007);
      rd(`ICW_W_DMA_MIN, 16'h0200);
      rd(`ICW_W_DMA_REC, 16'h0200);
      cv.dma_rec_ns = 16'h0300;
      setc();
      rd(`ICW_W_DMA_REC, 16'h0300);
      // Mode code 3 acts as mode 2; selecting mode 3 is not encodable
      cv.mdma_max = 2'h3;
      cv.mdma_sel = 2'h3;
      cv.mdma_sel_en = 1'b1;
      setc();
      rd(`ICW_W_MDMA, 16'h0007);
   endtask : t_mdma

   task automatic t_pio;
      cv = '0;
      cv.pio_nfc_ns = 16'h0064;
      setc();
      rd(`ICW_W_PIO, 16'h0000);
      rd(`ICW_W_PIO_NFC, 16'h0000);
      check("modes_valid", {15'h0, modes_valid}, 16'h0000);
      cv.pio3_sup = 1'b1;
      setc();
      rd(`ICW_W_PIO, 16'h0001);
      rd(`ICW_W_PIO_FC, `ICW_PIO3_NS);
      rd(`ICW_W_PIO_NFC, `ICW_PIO3_NS);
      rd(`ICW_W_DMA_MIN, 16'h0000);
      check("modes_valid", {15'h0, modes_valid}, 16'h0001);
      cv.pio4_sup = 1'b1;
      cv.pio_nfc_ns = 16'h01f4;
      cv.pio_fc_ns = 16'h0200;
      setc();
      rd(`ICW_W_PIO, 16'h0003);
      rd(`ICW_W_PIO_FC, `ICW_PIO4_NS);
      rd(`ICW_W_PIO_NFC, 16'h01f4);
   endtask : t_pio

   task automatic t_serial;
      logic        v;
      logic [15:0] w;
      cv = '0;
      cv.phy_evt = 1'b1;
      cv.host_pm = 1'b1;
      cv.ncq = 1'b1;
      cv.gen2 = 1'b1;
      cv.gen1 = 1'b1;
      cv.sfeat_sup = 6'h2a;
      setc();
      rd(`ICW_W_SCAP, 16'h0706);
      rd(`ICW_W_SFEAT, 16'h0054);
      rd(`ICW_W_SEN, 16'h0000);
      host.write_en(6'h3f);
      #1;
      check("feat_en", {10'h0, feat_en}, 16'h002a);
      rd(`ICW_W_SEN, 16'h0054);
      cv.phy_evt = 1'b0;
      cv.gen1 = 1'b0;
      setc();
      rd(`ICW_W_SCAP, 16'h0304);
      host.write_then_read(6'h0c, `ICW_W_SEN, v, w);
      check("enabled valid", {15'h0, v}, 16'h0001);
      check("enabled word", w, 16'h0010);
      host.write_en(6'h00);
      rd(`ICW_W_SEN, 16'h0000);
   endtask : t_serial

   task automatic t_cmd;
      logic        v;
      logic [15:0] w;
      for (int k = 0; k < 8; k++) begin
         cv.security_sup = k[0];
         cv.wcache_sup = k[1];
         cv.lookahead_sup = k[2];
         cv.apm_sup = k[0];
         setc();
         rd(`ICW_W_CMD0, 16'h7008 |
            {9'h0, k[2], k[1], 3'h0, k[0], 1'b0});
         rd(`ICW_W_CMD1, {12'h400, k[0], 3'h0});
         rd(`ICW_W_CMD2, 16'h4000);
      end
      rd(8'h3e, 16'h0000);
      rd(8'h4d, 16'h0000);
      rd(8'hc8, 16'h0000);
      host.read_word(`ICW_W_CMD2, v, w);
      check("word 84 indicated", {15'h0, host.indicated(w)}, 16'h0001);
   endtask : t_cmd

   initial begin
      repeat (5000) @(posedge core_clk);
      failures++;
      conclude();
   end

   initial begin
      failures = 0;
      checks_done = 0;
      reset_n = 1'b0;
      cv = '0;
      cfg = '0;
      repeat (5) @(posedge core_clk);
      #1;
      check("rd_valid in reset", {15'h0, rd_valid}, 16'h0000);
      check("feat_en in reset", {10'h0, feat_en}, 16'h0000);
      @(posedge core_clk);
      reset_n <= 1'b1;
      t_geom();
      t_mdma();
      t_pio();
      t_serial();
      t_cmd();
      conclude();
   end
endmodule : testbench
